// File: dv/apc_far.sv
// Far-side model: network status lines, aux input line and pushbutton.
`default_nettype none
// ****************************************************************
// Contact model
// ****************************************************************
module apc_far (
  input  wire logic               clk,
  input  wire apc_pkg::apc_pins_t want,
  output var apc_pkg::apc_pins_t  pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]         bnc = 4'h0;
  logic [1:0]         lvl = 2'h0;
  apc_pkg::apc_pins_t next_pins;
  // Mechanical contacts chatter after each change, so the debounce is really exercised.
  always_comb begin
    next_pins = want;
    if (bnc != 4'h0) begin
      next_pins.btn    = bnc[0] ^ lvl[1];
      next_pins.aux_in = bnc[1] ^ lvl[0];
    end
  end
  always_ff @(posedge clk) begin
    pins <= next_pins;
    lvl  <= {want.btn, want.aux_in};
    if (lvl != {want.btn, want.aux_in}) begin
      bnc <= 4'hF;
    end else if (bnc != 4'h0) begin
      bnc <= bnc - 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench of the aux port, indicator and preset controller.
`default_nettype none
`include "apc_cfg.svh"
// ****************************************************************
// Bench
// ****************************************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 4;
  logic                  clk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  ce = 1'b1;
  logic                  cmd_rx = 1'b0;
  apc_pkg::apc_apb_req_t req = '0;
  apc_pkg::apc_pins_t    want = '0;
  apc_pkg::apc_pins_t    pins;
  apc_pkg::apc_ind_t     ind;
  apc_pkg::apc_set_t     s;
  logic [31:0]           prdata, rq, seed = 32'hA;
  logic                  pready, pslverr, re, sec_port_en, aux_out;
  logic [1:0]            src_sel, ch_mute, ch_on;
  int                    miscompares = 0, check_count = 0, lit, up;
  always #4 clk = ~clk;
  apc_far i_apc_far (.clk(clk), .want(want), .pins(pins));
  apc_top #(.TICK_CYC(MS)) i_apc_top (.clk(clk), .sys_rst(sys_rst), .ce(ce), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .cmd_rx(cmd_rx), .ind(ind), .sec_port_en(sec_port_en),
    .src_sel(src_sel), .aux_out(aux_out), .ch_mute(ch_mute), .ch_on(ch_on));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [3:0] exp_ch(input logic [2:0] m, input logic act);
    logic [1:0] k;
    k = m < 3'h4 ? m[1:0] : 2'(m - 3'h3);
    return {(act && m < 3'h4) ? k : 2'h0, (act && m > 3'h3) ? ~k : 2'h3};
  endfunction
  task automatic print_verdict();
    if (miscompares == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // The master holds the whole request until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      miscompares++;
      print_verdict();
    end
    rq = prdata;
    re = pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic watch(input int len, input int k);
    logic v;
    logic p;
    lit = 0;
    up = 0;
    p = 1'b1;
    repeat (len) begin
      @(posedge clk);
      v = k == 0 ? ind.led_preset : k == 1 ? ind.led_data : k == 2 ? ind.led_use_pri : aux_out ^ ind.led_preset;
      lit += int'(v);
      up += int'(v & !p);
      p = v;
    end
  endtask
  initial begin
    want.btn = 1'b1;
    want.link = 1'b1;
    want.link_pri = 1'b1;
    want.net_ok = 1'b1;
    cyc(10);
    sys_rst <= 1'b0;
    cyc(100 * MS);
    chk("pup lamps", 32'({ind.led_data, ind.led_preset}), 32'h3);
    want.btn <= 1'b0;
    cyc(60 * MS);
    rd(`APC_REG_STAT);
    chk("factory busy", 32'(rq[10]), 32'h1);
    rd(`APC_REG_SET);
    chk("set reset", rq, 32'(`APC_SET_DEFAULT));
    chk("chan on", 32'(ch_on), 32'h3);
    rd(8'h0C);
    chk("unmapped", 32'(re), 32'h1);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      want.speed100 <= seed[0];
      want.link_pri <= seed[1];
      want.net_ok <= seed[2];
      want.override <= seed[3];
      want.use_pri <= seed[4];
      want.use_sec <= seed[5];
      cyc(6);
      chk("speed lamp", 32'(ind.led_speed), 32'(seed[0]));
      chk("sec port", 32'(sec_port_en), 32'(!seed[1]));
      chk("source", 32'(src_sel), seed[3] ? 32'h2 : 32'(!seed[2]));
      chk("use lamp", 32'(ind.led_use_pri), 32'(seed[4]));
      chk("use sec lamp", 32'(ind.led_use_sec), 32'(seed[5]));
    end
    want.use_pri <= 1'b1;
    want.conductor <= 1'b1;
    watch(600 * MS, 2);
    chk("conductor blink", 32'(lit > 0 && lit < 600 * MS), 32'h1);
    want.traffic <= 1'b1;
    cyc(2);
    want.traffic <= 1'b0;
    cyc(20 * MS);
    chk("traffic flash", 32'(ind.led_link), 32'h0);
    cyc(60 * MS);
    chk("link lamp", 32'(ind.led_link), 32'h1);
    ce <= 1'b0;
    want.link <= 1'b0;
    cyc(8);
    chk("ce hold", 32'(ind.led_link), 32'h1);
    ce <= 1'b1;
    cyc(8);
    chk("link lost", 32'(ind.led_link), 32'h0);
    want.link <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      seed = xs(seed);
      s = apc_pkg::apc_set_t'(`APC_SET_DEFAULT);
      s.out_mode = {1'b0, seed[0]};
      s.out_man = seed[1];
      s.out_inv = seed[2];
      s.err_en = seed[7:3];
      want.err <= seed[12:8];
      wr(`APC_REG_SET, {6'h0, s});
      cyc(4);
      chk("aux out", 32'(aux_out), 32'((seed[0] ? |(seed[7:3] & seed[12:8]) : seed[1]) ^ seed[2]));
    end
    s = apc_pkg::apc_set_t'(`APC_SET_DEFAULT);
    s.out_mode = 2'h2;
    s.out_inv = 1'b1;
    s.in_mode = 3'h7;
    s.pmin = 4'h2;
    s.pmax = 4'h4;
    wr(`APC_REG_SET, {6'h0, s});
    for (int p = 2; p <= 4; p++) wr(`APC_REG_CMD, 32'h10 | p);
    wr(`APC_REG_CMD, 32'h1B);
    wr(`APC_REG_CMD, 32'h10);
    rd(`APC_REG_STAT);
    chk("store mon", 32'(rq[6:2]), 32'h9);
    wr(`APC_REG_SET, 32'(`APC_SET_DEFAULT));
    rd(`APC_REG_STAT);
    chk("changed mon", 32'(rq[6:2]), 32'h8);
    wr(`APC_REG_CMD, 32'h23);
    rd(`APC_REG_SET);
    chk("recall", rq, {6'h0, s});
    rd(`APC_REG_STAT);
    chk("recall mon", 32'(rq[6:2]), 32'h7);
    watch(3000 * MS, 0);
    chk("preset flashes", 32'(up), 32'h3);
    watch(2000 * MS, 3);
    chk("aux flash", 32'(lit), 32'h0);
    wr(`APC_REG_SET, 32'(`APC_SET_DEFAULT));
    watch(1000 * MS, 0);
    chk("preset dark", 32'(lit), 32'h0);
    cmd_rx <= 1'b1;
    @(posedge clk);
    cmd_rx <= 1'b0;
    cyc(3);
    chk("cmd lamp", 32'(ind.led_data), 32'h1);
    cyc(60 * MS);
    chk("cmd lamp off", 32'(ind.led_data), 32'h0);
    wr(`APC_REG_CMD, 32'h23);
    for (int i = 0; i < 3; i++) begin
      want.aux_in <= !i[0];
      cyc(40 * MS);
      rd(`APC_REG_STAT);
      chk("cycle preset", 32'(rq[6:3]), i == 2 ? 32'h2 : 32'h4);
    end
    want.btn <= 1'b1;
    cyc(100 * MS);
    want.btn <= 1'b0;
    cyc(60 * MS);
    rd(`APC_REG_STAT);
    chk("short press", 32'(rq[6:3]), 32'h3);
    want.btn <= 1'b1;
    watch(2100 * MS, 1);
    chk("hold flashes", 32'(up >= 2), 32'h1);
    want.btn <= 1'b0;
    cyc(60 * MS);
    rd(`APC_REG_SET);
    chk("long press", rq, 32'(`APC_SET_DEFAULT));
    rd(`APC_REG_STAT);
    chk("rapid flash", 32'(rq[10]), 32'h1);
    for (int m = 0; m < 7; m++) begin
      logic a;
      seed = xs(seed);
      a = seed[1] || m == 3;
      s = apc_pkg::apc_set_t'(`APC_SET_DEFAULT);
      s.in_mode = 3'(m);
      s.in_inv = seed[0];
      want.aux_in <= seed[0] ^ a;
      wr(`APC_REG_SET, {6'h0, s});
      cyc(30 * MS);
      chk("channels", 32'({ch_mute, ch_on}), 32'(exp_ch(3'(m), a)));
      rd(`APC_REG_STAT);
      chk("aux status", 32'(rq[1:0]), 32'({a, seed[0] ^ a}));
    end
    cyc(1000 * MS);
    s = apc_pkg::apc_set_t'(`APC_SET_DEFAULT);
    s.data_force = 1'b1;
    wr(`APC_REG_SET, {6'h0, s});
    cyc(3);
    watch(100 * MS, 1);
    chk("data forced", 32'(lit), 32'(100 * MS));
    print_verdict();
  end
endmodule
`default_nettype wire

// File: verilog/apc_cfg.svh
// Constants of the aux port, indicator and preset controller.
`ifndef APC_CFG_SVH
`define APC_CFG_SVH
`define APC_CLK_HZ 125000000
`define APC_TICK_NS 1000000
`define APC_TICK_CYC (`APC_TICK_NS / (1000000000 / `APC_CLK_HZ))
`define APC_DEB_MS 20
`define APC_BOOT_MS 40
`define APC_LONG_MS 2000
`define APC_PUP_MS 5000
`define APC_HOLD_PER_MS 1000
`define APC_HOLD_ON_MS 500
`define APC_RAPID_MS 1000
`define APC_RAPID_HALF_MS 50
`define APC_PF_ON_MS 250
`define APC_PF_OFF_MS 250
`define APC_PF_PAUSE_MS 1500
`define APC_CMD_MS 50
`define APC_TRAF_MS 50
`define APC_COND_HALF_MS 250
`define APC_NUM_PRESETS 10
`define APC_REG_SET 8'h00
`define APC_REG_CMD 8'h04
`define APC_REG_STAT 8'h08
`define APC_CMD_STORE 4
`define APC_CMD_RECALL 5
`define APC_OUT_MANUAL 2'h0
`define APC_OUT_ERROR 2'h1
`define APC_OUT_FLASH 2'h2
`define APC_IN_NONE 3'h0
`define APC_IN_MUTE1 3'h1
`define APC_IN_MUTE2 3'h2
`define APC_IN_MUTEB 3'h3
`define APC_IN_PWR1 3'h4
`define APC_IN_PWR2 3'h5
`define APC_IN_PWRB 3'h6
`define APC_IN_CYCLE 3'h7
`define APC_SRC_NET 2'h0
`define APC_SRC_ANALOG 2'h1
`define APC_SRC_OVR 2'h2
`define APC_SET_DEFAULT 26'h180001A
`endif

// File: verilog/apc_pkg.sv
// Types shared by the aux port, indicator and preset controller.
`default_nettype none
package apc_pkg;
  typedef struct packed {
    logic       data_force;
    logic [1:0] pwr;
    logic [1:0] mute;
    logic [1:0] out_mode;
    logic       out_inv;
    logic       out_man;
    logic [4:0] err_en;
    logic [2:0] in_mode;
    logic       in_inv;
    logic [3:0] pmin;
    logic [3:0] pmax;
  } apc_set_t;
  typedef struct packed {
    logic       link;
    logic       speed100;
    logic       traffic;
    logic       link_pri;
    logic       use_pri;
    logic       use_sec;
    logic       conductor;
    logic       net_ok;
    logic       override;
    logic [4:0] err;
    logic       aux_in;
    logic       btn;
  } apc_pins_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apc_apb_req_t;
  typedef struct packed {
    logic led_link;
    logic led_speed;
    logic led_use_pri;
    logic led_use_sec;
    logic led_data;
    logic led_preset;
  } apc_ind_t;
  typedef struct packed {
    logic [20:0] zero;
    logic        factory;
    logic [1:0]  src;
    logic        sec_en;
    logic [3:0]  last;
    logic        valid;
    logic        active;
    logic        raw;
  } apc_stat_t;
  typedef enum logic [2:0] {BT_BOOT, BT_PUP, BT_IDLE, BT_HELD, BT_WAIT} apc_btn_t;
  typedef enum logic [1:0] {PF_ON, PF_OFF, PF_PAUSE} apc_pf_t;
endpackage
`default_nettype wire

// File: verilog/apc_top.sv
// Aux port, indicator, failover and preset controller with an APB slave.
`default_nettype none
`include "apc_cfg.svh"
// ****************************************************************
// Operation
// - Link lamp lit on link, flashes on traffic.
// - Speed lamp lit only on 100 Mb link.
// - Primary link lost enables secondary port.
// - In-use lamp on; blinks when timing reference.
// - Network audio lost selects analog inputs.
// - Detected override signal becomes audio source.
// - Manual mode: aux output follows software.
// - Error mode: aux output on enabled errors.
// - Flash mode: aux output copies preset pattern.
// - Output inversion in manual, error modes only.
// - Input mode none acts not, still reports.
// - Active input mutes or powers off channels.
// - Cycle mode advances preset on active edge.
// - High input active unless inversion set.
// - Short press loads next preset, wrapping.
// - Long press restores settings, rapid data flash.
// - Held at power-up: lamps lit, full restore on release within 5 s.
// - Data lamp flashes while button held.
// - Ten preset slots with store and recall.
// - Flag changes since preset; report last preset.
// - Per channel power and mute control.
// - Preset lamp flashes number, pause; stops on change.
// - Data lamp flashes on command; force option.
// ****************************************************************
module apc_top #(
  parameter int TICK_CYC    = `APC_TICK_CYC,
  parameter int NUM_PRESETS = `APC_NUM_PRESETS
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ce,
  input  wire apc_pkg::apc_apb_req_t apb_req,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire apc_pkg::apc_pins_t    pins,
  input  wire logic                  cmd_rx,
  output var apc_pkg::apc_ind_t      ind,
  output logic                       sec_port_en,
  output logic [1:0]                 src_sel,
  output logic                       aux_out,
  output logic [1:0]                 ch_mute,
  output logic [1:0]                 ch_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  if (TICK_CYC < 2 || NUM_PRESETS < 1 || NUM_PRESETS > 15) begin : g_bad_param
    $error("apc_top: unsupported parameter value");
  end

  // ****************************************************************
  // Input synchronisers and millisecond tick
  // ****************************************************************
  apc_pkg::apc_pins_t pins_m;
  apc_pkg::apc_pins_t pins_s;
  logic [31:0]        tick_cnt;
  logic               tick;
  logic [15:0]        ms;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pins_m <= '0;
      pins_s <= '0;
    end else if (ce) begin
      pins_m <= pins;
      pins_s <= pins_m;
    end
  end

  assign tick = ce && (tick_cnt == 32'(TICK_CYC - 1));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= 32'h0;
      ms       <= 16'h0;
    end else if (ce) begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
      if (tick) begin
        ms <= ms + 16'h1;
      end
    end
  end

  // ****************************************************************
  // Debounce of button and aux input
  // ****************************************************************
  logic [1:0] raw_in;
  logic       deb [2];

  assign raw_in = {pins_s.aux_in, pins_s.btn};

  for (genvar i = 0; i < 2; i++) begin : g_deb
    logic [7:0] cnt;
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        cnt    <= 8'h0;
        deb[i] <= 1'b0;
      end else if (ce) begin
        if (raw_in[i] == deb[i]) begin
          cnt <= 8'h0;
        end else if (tick) begin
          if (cnt == 8'(`APC_DEB_MS - 1)) begin
            deb[i] <= raw_in[i];
            cnt    <= 8'h0;
          end else begin
            cnt <= cnt + 8'h1;
          end
        end
      end
    end
  end

  // ****************************************************************
  // Settings, presets and register decode
  // ****************************************************************
  apc_pkg::apc_set_t s;
  apc_pkg::apc_set_t bank [NUM_PRESETS];
  logic              valid;
  logic [3:0]        last;
  logic              aux_act;
  logic              aux_act_d;
  logic              acc;
  logic              wr_set;
  logic              wr_cmd;
  logic [3:0]        cmd_num;
  logic              cmd_ok;
  logic              st_go;
  logic              rc_apb;
  logic [3:0]        nxt_num;
  logic              nxt_ok;
  logic              cyc_go;
  logic              short_go;
  logic              fac_set;
  logic              fac_all;
  logic              rcl_go;
  logic [3:0]        rcl_num;
  logic [12:0]       rapid_ms;

  assign aux_act = deb[1] ^ s.in_inv;
  assign acc     = apb_req.psel && apb_req.penable;
  assign pready  = acc;
  assign wr_set  = acc && apb_req.pwrite && apb_req.paddr == `APC_REG_SET;
  assign wr_cmd  = acc && apb_req.pwrite && apb_req.paddr == `APC_REG_CMD;
  assign cmd_num = apb_req.pwdata[3:0];
  assign cmd_ok  = cmd_num != 4'h0 && cmd_num <= 4'(NUM_PRESETS);
  assign st_go   = ce && wr_cmd && cmd_ok && apb_req.pwdata[`APC_CMD_STORE];
  assign rc_apb  = ce && wr_cmd && cmd_ok && apb_req.pwdata[`APC_CMD_RECALL];
  // A range that runs past the last slot is clipped by refusing the step.
  assign nxt_num = (last >= s.pmax || last < s.pmin) ? s.pmin : last + 4'h1;
  assign nxt_ok  = nxt_num != 4'h0 && nxt_num <= 4'(NUM_PRESETS);
  assign cyc_go  = ce && s.in_mode == `APC_IN_CYCLE && aux_act && !aux_act_d && nxt_ok;
  assign rcl_go  = rc_apb || ((cyc_go || (short_go && ce)) && nxt_ok);
  assign rcl_num = rc_apb ? cmd_num : nxt_num;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_act_d <= 1'b0;
    end else if (ce) begin
      aux_act_d <= aux_act;
    end
  end

  // Slots are held in flops; a real part backs them with external storage.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int k = 0; k < NUM_PRESETS; k++) begin
        bank[k] <= `APC_SET_DEFAULT;
      end
    end else if (ce) begin
      if (fac_all) begin
        for (int k = 0; k < NUM_PRESETS; k++) begin
          bank[k] <= `APC_SET_DEFAULT;
        end
      end else if (st_go) begin
        bank[4'(cmd_num - 4'h1)] <= s;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s     <= `APC_SET_DEFAULT;
      valid <= 1'b0;
      last  <= 4'h0;
    end else if (ce) begin
      if (fac_set || fac_all) begin
        s     <= `APC_SET_DEFAULT;
        valid <= 1'b0;
      end else if (rcl_go) begin
        s     <= bank[4'(rcl_num - 4'h1)];
        valid <= 1'b1;
        last  <= rcl_num;
      end else if (st_go) begin
        valid <= 1'b1;
        last  <= cmd_num;
      end else if (wr_set) begin
        s     <= apb_req.pwdata[25:0];
        valid <= 1'b0;
      end
    end
  end

  apc_pkg::apc_stat_t stat;
  logic [31:0]        rd_mux;

  always_comb begin
    stat         = '0;
    stat.raw     = deb[1];
    stat.active  = aux_act;
    stat.valid   = valid;
    stat.last    = last;
    stat.sec_en  = sec_port_en;
    stat.src     = src_sel;
    stat.factory = rapid_ms != 13'h0;
  end

  always_comb begin
    if (apb_req.paddr == `APC_REG_SET) begin
      rd_mux = {6'h00, s};
    end else if (apb_req.paddr == `APC_REG_STAT) begin
      rd_mux = stat;
    end else begin
      rd_mux = 32'h0;
    end
  end

  assign pslverr = acc && apb_req.paddr != `APC_REG_SET && apb_req.paddr != `APC_REG_CMD
                   && apb_req.paddr != `APC_REG_STAT;

  // Read data is caught in the setup cycle so the access phase needs no wait.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0;
    end else if (ce && apb_req.psel && !apb_req.penable) begin
      prdata <= rd_mux;
    end
  end

  // ****************************************************************
  // Pushbutton decoder
  // ****************************************************************
  apc_pkg::apc_btn_t bt;
  logic [12:0]       bt_ms;

  assign short_go = bt == apc_pkg::BT_HELD && !deb[0] && bt_ms < 13'(`APC_LONG_MS);
  assign fac_set  = ce && bt == apc_pkg::BT_HELD && !deb[0] && bt_ms >= 13'(`APC_LONG_MS);
  assign fac_all  = ce && bt == apc_pkg::BT_PUP && !deb[0];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bt    <= apc_pkg::BT_BOOT;
      bt_ms <= 13'h0;
    end else if (ce) begin
      case (bt)
        apc_pkg::BT_BOOT: begin
          if (tick) begin
            bt_ms <= bt_ms + 13'h1;
            if (bt_ms == 13'(`APC_BOOT_MS)) begin
              bt    <= deb[0] ? apc_pkg::BT_PUP : apc_pkg::BT_IDLE;
              bt_ms <= 13'h0;
            end
          end
        end
        apc_pkg::BT_PUP: begin
          if (!deb[0]) begin
            bt <= apc_pkg::BT_IDLE;
          end else if (tick) begin
            bt_ms <= bt_ms + 13'h1;
            if (bt_ms == 13'(`APC_PUP_MS - 1)) begin
              bt <= apc_pkg::BT_WAIT;
            end
          end
        end
        apc_pkg::BT_IDLE: begin
          if (deb[0]) begin
            bt    <= apc_pkg::BT_HELD;
            bt_ms <= 13'h0;
          end
        end
        apc_pkg::BT_HELD: begin
          if (!deb[0]) begin
            bt <= apc_pkg::BT_IDLE;
          end else if (tick && bt_ms != 13'h1FFF) begin
            bt_ms <= bt_ms + 13'h1;
          end
        end
        apc_pkg::BT_WAIT: begin
          if (!deb[0]) begin
            bt <= apc_pkg::BT_IDLE;
          end
        end
        default: begin
          bt <= apc_pkg::BT_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Flash timers
  // ****************************************************************
  apc_pkg::apc_pf_t pf;
  logic [10:0]      pf_ms;
  logic [3:0]       pf_idx;
  logic             pre_pat;
  logic [6:0]       cmd_ms;
  logic [6:0]       traf_ms;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rapid_ms <= 13'h0;
      cmd_ms   <= 7'h0;
      traf_ms  <= 7'h0;
    end else if (ce) begin
      if (fac_set || fac_all) begin
        rapid_ms <= 13'(`APC_RAPID_MS);
      end else if (tick && rapid_ms != 13'h0) begin
        rapid_ms <= rapid_ms - 13'h1;
      end
      if (cmd_rx) begin
        cmd_ms <= 7'(`APC_CMD_MS);
      end else if (tick && cmd_ms != 7'h0) begin
        cmd_ms <= cmd_ms - 7'h1;
      end
      if (pins_s.traffic && traf_ms == 7'h0) begin
        traf_ms <= 7'(2 * `APC_TRAF_MS);
      end else if (tick && traf_ms != 7'h0) begin
        traf_ms <= traf_ms - 7'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pf     <= apc_pkg::PF_PAUSE;
      pf_ms  <= 11'h0;
      pf_idx <= 4'h0;
    end else if (ce) begin
      if (!valid) begin
        pf     <= apc_pkg::PF_PAUSE;
        pf_ms  <= 11'h0;
        pf_idx <= 4'h0;
      end else if (tick) begin
        pf_ms <= pf_ms + 11'h1;
        case (pf)
          apc_pkg::PF_ON: begin
            if (pf_ms == 11'(`APC_PF_ON_MS - 1)) begin
              pf     <= apc_pkg::PF_OFF;
              pf_ms  <= 11'h0;
              pf_idx <= pf_idx + 4'h1;
            end
          end
          apc_pkg::PF_OFF: begin
            if (pf_ms == 11'(`APC_PF_OFF_MS - 1)) begin
              pf    <= (pf_idx >= last) ? apc_pkg::PF_PAUSE : apc_pkg::PF_ON;
              pf_ms <= 11'h0;
            end
          end
          default: begin
            if (pf_ms == 11'(`APC_PF_PAUSE_MS - 1)) begin
              pf     <= apc_pkg::PF_ON;
              pf_ms  <= 11'h0;
              pf_idx <= 4'h0;
            end
          end
        endcase
      end
    end
  end

  assign pre_pat = valid && pf == apc_pkg::PF_ON;

  // ****************************************************************
  // Indicators and control outputs
  // ****************************************************************
  logic       data_nx;
  logic       cond_blink;
  logic [1:0] aux_mute;
  logic [1:0] aux_off;
  logic       aux_nx;

  assign cond_blink = (ms % 16'(2 * `APC_COND_HALF_MS)) < 16'(`APC_COND_HALF_MS);

  always_comb begin
    if (rapid_ms != 13'h0) begin
      data_nx = (rapid_ms % 13'(2 * `APC_RAPID_HALF_MS)) >= 13'(`APC_RAPID_HALF_MS);
    end else if (bt == apc_pkg::BT_PUP) begin
      data_nx = 1'b1;
    end else if (bt == apc_pkg::BT_HELD) begin
      data_nx = (bt_ms % 13'(`APC_HOLD_PER_MS)) < 13'(`APC_HOLD_ON_MS);
    end else begin
      data_nx = s.data_force || cmd_ms != 7'h0;
    end
  end

  always_comb begin
    aux_mute = 2'h0;
    aux_off  = 2'h0;
    if (aux_act) begin
      case (s.in_mode)
        `APC_IN_MUTE1: aux_mute = 2'h1;
        `APC_IN_MUTE2: aux_mute = 2'h2;
        `APC_IN_MUTEB: aux_mute = 2'h3;
        `APC_IN_PWR1:  aux_off  = 2'h1;
        `APC_IN_PWR2:  aux_off  = 2'h2;
        `APC_IN_PWRB:  aux_off  = 2'h3;
        default:       aux_off  = 2'h0;
      endcase
    end
  end

  always_comb begin
    case (s.out_mode)
      `APC_OUT_MANUAL: aux_nx = s.out_man ^ s.out_inv;
      `APC_OUT_ERROR:  aux_nx = (|(pins_s.err & s.err_en)) ^ s.out_inv;
      `APC_OUT_FLASH:  aux_nx = pre_pat;
      default:         aux_nx = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ind         <= '0;
      sec_port_en <= 1'b0;
      src_sel     <= `APC_SRC_NET;
      aux_out     <= 1'b0;
      ch_mute     <= 2'h0;
      ch_on       <= 2'h0;
    end else if (ce) begin
      ind.led_link    <= pins_s.link && traf_ms <= 7'(`APC_TRAF_MS);
      ind.led_speed   <= pins_s.link && pins_s.speed100;
      ind.led_use_pri <= pins_s.use_pri && (!pins_s.conductor || cond_blink);
      ind.led_use_sec <= pins_s.use_sec && (!pins_s.conductor || cond_blink);
      ind.led_data    <= data_nx;
      ind.led_preset  <= bt == apc_pkg::BT_PUP || pre_pat;
      sec_port_en     <= !pins_s.link_pri;
      if (pins_s.override) begin
        src_sel <= `APC_SRC_OVR;
      end else if (!pins_s.net_ok) begin
        src_sel <= `APC_SRC_ANALOG;
      end else begin
        src_sel <= `APC_SRC_NET;
      end
      aux_out <= aux_nx;
      ch_mute <= s.mute | aux_mute;
      ch_on   <= s.pwr & ~aux_off;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_store;
    st_go && !rcl_go && !fac_set && !fac_all;
  endsequence

  sequence s_release_short;
    ce && short_go && nxt_ok && !rc_apb && !fac_all;
  endsequence

  chk_link_dark: assert property (ce && !pins_s.link |=> !ind.led_link)
    else $error("link lamp lit without link");
  chk_speed_lamp: assert property (ce && !pins_s.speed100 |=> !ind.led_speed)
    else $error("speed lamp lit on slow link");
  chk_sec_failover: assert property (ce && !pins_s.link_pri |=> sec_port_en)
    else $error("secondary port not enabled");
  chk_src_override: assert property (ce && pins_s.override |=> src_sel == `APC_SRC_OVR)
    else $error("override not selected");
  chk_src_backup: assert property (ce && !pins_s.override && !pins_s.net_ok |=> src_sel == `APC_SRC_ANALOG)
    else $error("analog backup not selected");
  chk_aux_manual: assert property (ce && s.out_mode == `APC_OUT_MANUAL |=> aux_out == $past(s.out_man ^ s.out_inv))
    else $error("manual aux output wrong");
  chk_aux_flash: assert property (ce && s.out_mode == `APC_OUT_FLASH |=> aux_out == $past(pre_pat))
    else $error("flash aux output wrong");
  chk_mute_both: assert property (ce && aux_act && s.in_mode == `APC_IN_MUTEB |=> ch_mute == 2'h3)
    else $error("aux mute not applied");
  chk_store_flag: assert property (s_store |=> valid && last == $past(cmd_num))
    else $error("store not reported");
  chk_short_next: assert property (s_release_short |=> last == $past(nxt_num) && valid)
    else $error("short press did not advance preset");
endmodule
`default_nettype wire
